// ### include/dps_params.svh
`ifndef DPS_PARAMS_SVH
`define DPS_PARAMS_SVH

// ****************************************
// Word format
// ****************************************
`define WORD_BITS        22
`define CTL_LSB          0
`define CTL_MSB          1
`define REF_CNT_LSB      2
`define REF_CNT_MSB      15
`define REF_POL_BIT      16
`define REF_TRI_BIT      17
`define REF_CUR_BIT      20
`define FB_SWALLOW_LSB   2
`define FB_SWALLOW_MSB   7
`define FB_MAIN_LSB      8
`define FB_MAIN_MSB      18
`define FB_PRESC_BIT     19
`define FB_PD_BIT        20

// ****************************************
// Reset values
// ****************************************
`define LATCH_RST        22'h000000
`define WRITTEN_RST      4'h0

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS    20
`define PD_SETTLE_NS     200
`define PD_SETTLE_CYC    ((`PD_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### include/dps_pkg.sv
package dps_pkg;

  // Power-down sequence of one loop, Gray coded
  typedef enum logic [1:0] {
    DPS_RUN    = 2'b00,
    DPS_CP_OFF = 2'b01,
    DPS_DOWN   = 2'b11
  } dps_pd_st_t;

  typedef struct packed {
    logic [21:0] ref_w;
    logic [21:0] fb_w;
    dps_pd_st_t  st;
    logic [7:0]  cnt;
    logic        hiz;
    logic        down;
  } dps_loop_t;

  typedef struct packed {
    logic            sclk_m;
    logic            sclk_s;
    logic            sclk_p;
    logic            data_m;
    logic            data_s;
    logic            le_m;
    logic            le_s;
    logic            le_p;
    logic [21:0]     sr;
    dps_loop_t [1:0] lp;
    logic            osc_en;
    logic [3:0]      written;
    logic            active;
    logic            mux_pin;
  } dps_state_t;

endpackage

// ### design/dps_serial_ctrl.sv
`timescale 1ns/1ns
`include "dps_params.svh"

// Summary of operation
// R1: Shift 22 bits; latch on strobe rise.
// R2: Control 00 loads secondary reference divider.
// R3: Control 01 loads secondary swallow/main divider.
// R4: Control 10 loads primary reference divider.
// R5: Control 11 loads primary swallow/main divider.
// R6: Secondary power-down: tristate pump, then down.
// R7: Secondary already tristated: down on strobe.
// R8: Primary power-down: tristate pump, then down.
// R9: Primary already tristated: down on strobe.
// R10: Power-down holds dividers loaded, input debiased.
// R11: Oscillator off only when both down; code stops it once both power-down bits are stored, even in DPS_CP_OFF.
// R12: Shift register and latches work in power-down.
// R13: Storing power-down 0 resumes loop at once.
// R14: Secondary polarity bit sets detector sense.
// R15: Primary polarity bit sets detector sense.
// R16: Secondary tristate bit floats secondary pump.
// R17: Primary tristate bit floats primary pump.
// R18: Secondary reference latch bit sets pump current.
// R19: Secondary feedback latch bit selects prescaler.
// R20: Primary feedback latch bit selects prescaler.
// R21: Primary gain bit enters fastlock, closes switch.
// R22: Host frames 22 bits, then raises strobe.
// R23: Host writes all four latches after power-up.
// R24: Host keeps main count not below swallow.
// R25: Words arrive MSB first, control bits last.

module dps_serial_ctrl (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Serial link pins
  input  wire logic        serial_clk,
  input  wire logic        serial_data_in,
  input  wire logic        latch_strobe,
  // Secondary loop
  output logic [13:0]      secondary_ref_count,
  output logic [5:0]       secondary_swallow_count,
  output logic [10:0]      secondary_main_count,
  output logic             secondary_prescaler_select,
  output logic             secondary_pfd_polarity,
  output logic             secondary_cp_current,
  output logic             secondary_cp_hiz,
  output logic             secondary_powered_down,
  // Primary loop
  output logic [13:0]      primary_ref_count,
  output logic [5:0]       primary_swallow_count,
  output logic [10:0]      primary_main_count,
  output logic             primary_prescaler_select,
  output logic             primary_pfd_polarity,
  output logic             primary_cp_gain,
  output logic             primary_cp_hiz,
  output logic             primary_powered_down,
  // Shared
  output logic             multiplexed_output_pin,
  output logic             ref_osc_enable,
  output logic             outputs_active
);

  // ****************************************
  // Helpers
  // ****************************************
  localparam logic [7:0] PD_CYC = 8'(`PD_SETTLE_CYC);

  dps_pkg::dps_state_t st_q;
  dps_pkg::dps_state_t st_d;
  logic                sclk_rise;
  logic                le_rise;
  logic [1:0]          ctl;

  // Latch targeted by the control bits: high bit picks loop, low bit picks divider
  function automatic logic hits(input logic [1:0] c, input logic loop_sel, input logic is_fb);
    hits = (c[1] == loop_sel) && (c[0] == is_fb);
  endfunction

  // Power-down sequencing of one loop, run every clock on the latch contents, freshly stored words included
  function automatic dps_pkg::dps_loop_t step(input dps_pkg::dps_loop_t l);
    dps_pkg::dps_loop_t n;
    logic               pd;
    logic               tri_b;
    n = l;
    pd = l.fb_w[`FB_PD_BIT];
    tri_b = l.ref_w[`REF_TRI_BIT];
    case (l.st)
      dps_pkg::DPS_RUN: begin
        if (pd && tri_b) begin
          n.st = dps_pkg::DPS_DOWN;            // see R7 see R9
          n.down = 1'b1;
          n.hiz = 1'b1;
        end else if (pd) begin
          n.st = dps_pkg::DPS_CP_OFF;          // see R6 see R8
          n.hiz = 1'b1;
          n.cnt = PD_CYC;
        end else begin
          n.hiz = tri_b;                       // see R16 see R17
          n.down = 1'b0;
        end
      end
      dps_pkg::DPS_CP_OFF: begin
        if (!pd) begin
          n.st = dps_pkg::DPS_RUN;             // see R13
          n.hiz = tri_b;
        end else if (l.cnt <= 8'h01) begin
          n.st = dps_pkg::DPS_DOWN;            // see R6 see R8
          n.down = 1'b1;
          n.cnt = 8'h00;
        end else begin
          n.cnt = l.cnt - 8'h01;
        end
      end
      dps_pkg::DPS_DOWN: begin
        if (!pd) begin
          n.st = dps_pkg::DPS_RUN;             // see R13
          n.down = 1'b0;
          n.hiz = tri_b;
        end else begin
          n.hiz = 1'b1;
          n.down = 1'b1;                       // see R10
        end
      end
      default: begin
        n.st = dps_pkg::DPS_RUN;
        n.down = 1'b0;
        n.hiz = tri_b;
        n.cnt = 8'h00;
      end
    endcase
    step = n;
  endfunction

  assign sclk_rise = st_q.sclk_s & ~st_q.sclk_p;
  assign le_rise   = st_q.le_s & ~st_q.le_p;
  assign ctl       = st_q.sr[`CTL_MSB:`CTL_LSB];

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_d = st_q;
    st_d.sclk_m = serial_clk;
    st_d.sclk_s = st_q.sclk_m;
    st_d.sclk_p = st_q.sclk_s;
    st_d.data_m = serial_data_in;
    st_d.data_s = st_q.data_m;
    st_d.le_m = latch_strobe;
    st_d.le_s = st_q.le_m;
    st_d.le_p = st_q.le_s;
    if (sclk_rise) begin
      st_d.sr = {st_q.sr[20:0], st_q.data_s};  // see R1 see R25
    end
    // Latches accept words whatever the power-down state
    if (le_rise) begin
      for (int i = 0; i < 2; i++) begin
        if (hits(ctl, i[0], 1'b0)) begin
          st_d.lp[i].ref_w = st_q.sr;          // see R2 see R4 see R12
        end
        if (hits(ctl, i[0], 1'b1)) begin
          st_d.lp[i].fb_w = st_q.sr;           // see R3 see R5 see R12
        end
      end
      st_d.written[ctl] = 1'b1;
    end
    for (int i = 0; i < 2; i++) begin
      st_d.lp[i] = step(st_d.lp[i]);
    end
    st_d.osc_en = !(st_d.lp[0].fb_w[`FB_PD_BIT] && st_d.lp[1].fb_w[`FB_PD_BIT]); // see R11
    st_d.active = &st_d.written;
    st_d.mux_pin = st_d.lp[1].ref_w[`REF_CUR_BIT]; // see R21
    if (sys_rst) begin
      st_d = '0;
      st_d.lp[0].ref_w = `LATCH_RST;
      st_d.lp[0].fb_w = `LATCH_RST;
      st_d.lp[1].ref_w = `LATCH_RST;
      st_d.lp[1].fb_w = `LATCH_RST;
      st_d.lp[0].st = dps_pkg::DPS_RUN;
      st_d.lp[1].st = dps_pkg::DPS_RUN;
      st_d.written = `WRITTEN_RST;
      st_d.osc_en = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    st_q <= st_d;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign secondary_ref_count        = st_q.lp[0].ref_w[`REF_CNT_MSB:`REF_CNT_LSB];
  assign secondary_swallow_count    = st_q.lp[0].fb_w[`FB_SWALLOW_MSB:`FB_SWALLOW_LSB];
  assign secondary_main_count       = st_q.lp[0].fb_w[`FB_MAIN_MSB:`FB_MAIN_LSB];
  assign secondary_prescaler_select = st_q.lp[0].fb_w[`FB_PRESC_BIT];   // see R19
  assign secondary_pfd_polarity     = st_q.lp[0].ref_w[`REF_POL_BIT];   // see R14
  assign secondary_cp_current       = st_q.lp[0].ref_w[`REF_CUR_BIT];   // see R18
  assign secondary_cp_hiz           = st_q.lp[0].hiz;
  assign secondary_powered_down     = st_q.lp[0].down;
  assign primary_ref_count          = st_q.lp[1].ref_w[`REF_CNT_MSB:`REF_CNT_LSB];
  assign primary_swallow_count      = st_q.lp[1].fb_w[`FB_SWALLOW_MSB:`FB_SWALLOW_LSB];
  assign primary_main_count         = st_q.lp[1].fb_w[`FB_MAIN_MSB:`FB_MAIN_LSB];
  assign primary_prescaler_select   = st_q.lp[1].fb_w[`FB_PRESC_BIT];   // see R20
  assign primary_pfd_polarity       = st_q.lp[1].ref_w[`REF_POL_BIT];   // see R15
  assign primary_cp_gain            = st_q.lp[1].ref_w[`REF_CUR_BIT];   // see R21
  assign primary_cp_hiz             = st_q.lp[1].hiz;
  assign primary_powered_down       = st_q.lp[1].down;
  assign multiplexed_output_pin     = st_q.mux_pin;
  assign ref_osc_enable             = st_q.osc_en;
  assign outputs_active             = st_q.active;

  // ****************************************
  // Checks
  // ****************************************
  localparam int PD_MAX = `PD_SETTLE_CYC + 1;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  chk_shift_in_bit: assert property ( // see R1
    sclk_rise |=> st_q.sr == {$past(st_q.sr[20:0]), $past(st_q.data_s)})
    else $error("shift register did not take the serial bit");

  chk_load_sec_ref: assert property ( // see R2
    le_rise && ctl == 2'b00 |=> st_q.lp[0].ref_w == $past(st_q.sr))
    else $error("secondary reference latch not loaded");

  chk_load_sec_fb: assert property ( // see R3
    le_rise && ctl == 2'b01 |=> st_q.lp[0].fb_w == $past(st_q.sr))
    else $error("secondary feedback latch not loaded");

  chk_load_pri_ref: assert property ( // see R4
    le_rise && ctl == 2'b10 |=> st_q.lp[1].ref_w == $past(st_q.sr))
    else $error("primary reference latch not loaded");

  chk_load_pri_fb: assert property ( // see R5
    le_rise && ctl == 2'b11 |=> st_q.lp[1].fb_w == $past(st_q.sr))
    else $error("primary feedback latch not loaded");

  chk_sec_sync_pd: assert property ( // see R6
    le_rise && ctl == 2'b01 && st_q.sr[`FB_PD_BIT] && !st_q.lp[0].ref_w[`REF_TRI_BIT]
      && st_q.lp[0].st == dps_pkg::DPS_RUN
    |=> (secondary_cp_hiz && !secondary_powered_down)
        ##[1:PD_MAX] secondary_powered_down)
    else $error("secondary synchronous power-down out of order");

  chk_sec_async_pd: assert property ( // see R7
    le_rise && ctl == 2'b01 && st_q.sr[`FB_PD_BIT] && st_q.lp[0].ref_w[`REF_TRI_BIT]
    |=> secondary_powered_down && secondary_cp_hiz)
    else $error("secondary asynchronous power-down late");

  chk_pri_sync_pd: assert property ( // see R8
    le_rise && ctl == 2'b11 && st_q.sr[`FB_PD_BIT] && !st_q.lp[1].ref_w[`REF_TRI_BIT]
      && st_q.lp[1].st == dps_pkg::DPS_RUN
    |=> (primary_cp_hiz && !primary_powered_down)
        ##[1:PD_MAX] primary_powered_down)
    else $error("primary synchronous power-down out of order");

  chk_pri_async_pd: assert property ( // see R9
    le_rise && ctl == 2'b11 && st_q.sr[`FB_PD_BIT] && st_q.lp[1].ref_w[`REF_TRI_BIT]
    |=> primary_powered_down && primary_cp_hiz)
    else $error("primary asynchronous power-down late");

  chk_down_floats_pump: assert property ( // see R10
    secondary_powered_down |-> secondary_cp_hiz)
    else $error("powered-down loop with live charge pump");

  chk_osc_gate: assert property ( // see R11
    ref_osc_enable == !(st_q.lp[0].fb_w[`FB_PD_BIT] && st_q.lp[1].fb_w[`FB_PD_BIT]))
    else $error("oscillator gating wrong");

  chk_resume_run: assert property ( // see R13
    le_rise && ctl == 2'b11 && !st_q.sr[`FB_PD_BIT]
    |=> !primary_powered_down && primary_cp_hiz == st_q.lp[1].ref_w[`REF_TRI_BIT])
    else $error("primary loop did not resume");

  chk_fastlock_pin: assert property ( // see R21
    $rose(primary_cp_gain) |-> ##1 multiplexed_output_pin)
    else $error("fastlock switch not closed");

  chk_pri_down_floats: assert property ( // see R10
    primary_powered_down |-> primary_cp_hiz)
    else $error("powered-down primary loop with live charge pump");

  chk_sec_resume_run: assert property ( // see R13
    le_rise && ctl == 2'b01 && !st_q.sr[`FB_PD_BIT]
    |=> !secondary_powered_down && secondary_cp_hiz == st_q.lp[0].ref_w[`REF_TRI_BIT])
    else $error("secondary loop did not resume");

  chk_sec_tristate_bit: assert property ( // see R16
    le_rise && ctl == 2'b00 && st_q.sr[`REF_TRI_BIT] |=> secondary_cp_hiz)
    else $error("secondary charge pump not floated");

  chk_pri_tristate_bit: assert property ( // see R17
    le_rise && ctl == 2'b10 && st_q.sr[`REF_TRI_BIT] |=> primary_cp_hiz)
    else $error("primary charge pump not floated");

  chk_shift_holds: assert property ( // see R1
    !sclk_rise |=> $stable(st_q.sr))
    else $error("shift register moved without a serial clock edge");

  chk_load_while_down: assert property ( // see R12
    le_rise && ctl == 2'b10 && primary_powered_down
    |=> primary_ref_count == $past(st_q.sr[`REF_CNT_MSB:`REF_CNT_LSB]))
    else $error("reference latch ignored a word during power-down");

  chk_fastlock_exit: assert property ( // see R21
    $fell(primary_cp_gain) |-> !multiplexed_output_pin)
    else $error("fastlock switch left closed");

  chk_sec_pump_first: assert property ( // see R6
    st_q.lp[0].st == dps_pkg::DPS_CP_OFF |-> secondary_cp_hiz && !secondary_powered_down)
    else $error("secondary loop down before pump was floated");

  chk_pri_pump_first: assert property ( // see R8
    st_q.lp[1].st == dps_pkg::DPS_CP_OFF |-> primary_cp_hiz && !primary_powered_down)
    else $error("primary loop down before pump was floated");

  chk_sec_polarity: assert property ( // see R14
    le_rise && ctl == 2'b00 |=> secondary_pfd_polarity == $past(st_q.sr[`REF_POL_BIT]))
    else $error("secondary detector polarity not taken");

  chk_pri_polarity: assert property ( // see R15
    le_rise && ctl == 2'b10 |=> primary_pfd_polarity == $past(st_q.sr[`REF_POL_BIT]))
    else $error("primary detector polarity not taken");

  chk_sec_pump_current: assert property ( // see R18
    le_rise && ctl == 2'b00 |=> secondary_cp_current == $past(st_q.sr[`REF_CUR_BIT]))
    else $error("secondary pump current not taken");

  chk_sec_prescaler: assert property ( // see R19
    le_rise && ctl == 2'b01 |=> secondary_prescaler_select == $past(st_q.sr[`FB_PRESC_BIT]))
    else $error("secondary prescaler select not taken");

  chk_pri_prescaler: assert property ( // see R20
    le_rise && ctl == 2'b11 |=> primary_prescaler_select == $past(st_q.sr[`FB_PRESC_BIT]))
    else $error("primary prescaler select not taken");

  cov_sync_pd: cover property (
    st_q.lp[1].st == dps_pkg::DPS_CP_OFF ##1 st_q.lp[1].st == dps_pkg::DPS_DOWN);
  cov_load_in_down: cover property (le_rise && secondary_powered_down && primary_powered_down);
  cov_all_written: cover property ($rose(outputs_active));
  cov_osc_off: cover property ($fell(ref_osc_enable));
  cov_fastlock: cover property ($rose(multiplexed_output_pin));

endmodule

// ### verification/dps_host_model.sv
`timescale 1ns/1ns

// ****************************************
// Serial master on the far side of the link
// ****************************************
module dps_host_model (
  // Clock
  input  wire logic clk,
  // Serial link pins
  output logic      serial_clk,
  output logic      serial_data_in,
  output logic      latch_strobe
);
  initial begin
    serial_clk = 1'b0;
    serial_data_in = 1'b0;
    latch_strobe = 1'b0;
  end

  // Link clock of 160 ns, stands still between frames
  task automatic send_word(input logic [21:0] w);
    @(negedge clk);
    for (int i = 21; i >= 0; i--) begin
      serial_data_in = w[i];
      repeat (4) @(negedge clk);
      serial_clk = 1'b1;
      repeat (4) @(negedge clk);
      serial_clk = 1'b0;
    end
    repeat (4) @(negedge clk);
    latch_strobe = 1'b1;
    serial_data_in = ~serial_data_in;
    repeat (4) @(negedge clk);
    latch_strobe = 1'b0;
  endtask
endmodule

// ### verification/dps_serial_ctrl_test.sv
`timescale 1ns/1ns
`include "dps_params.svh"

module dps_serial_ctrl_test;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        serial_clk, serial_data_in, latch_strobe;
  logic [13:0] secondary_ref_count, primary_ref_count;
  logic [5:0]  secondary_swallow_count, primary_swallow_count;
  logic [10:0] secondary_main_count, primary_main_count;
  logic        secondary_prescaler_select, secondary_pfd_polarity, secondary_cp_current;
  logic        secondary_cp_hiz, secondary_powered_down, primary_prescaler_select;
  logic        primary_pfd_polarity, primary_cp_gain, primary_cp_hiz, primary_powered_down;
  logic        multiplexed_output_pin, ref_osc_enable, outputs_active;
  int          n_errors = 0;
  int          samples_checked = 0;

  always #10 clk = ~clk;

  dps_host_model i_dps_host_model (.clk, .serial_clk, .serial_data_in, .latch_strobe);

  dps_serial_ctrl i_dps_serial_ctrl (
    .clk, .sys_rst, .serial_clk, .serial_data_in, .latch_strobe,
    .secondary_ref_count, .secondary_swallow_count, .secondary_main_count,
    .secondary_prescaler_select, .secondary_pfd_polarity, .secondary_cp_current,
    .secondary_cp_hiz, .secondary_powered_down, .primary_ref_count,
    .primary_swallow_count, .primary_main_count, .primary_prescaler_select,
    .primary_pfd_polarity, .primary_cp_gain, .primary_cp_hiz, .primary_powered_down,
    .multiplexed_output_pin, .ref_osc_enable, .outputs_active
  );

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t: saw %0h, expected %0h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("Checked %0d values, %0d mismatches", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  function automatic logic [21:0] mk_ref(input logic lp, input logic [13:0] n,
                                         input logic pol, input logic ts, input logic cur);
    return {1'b0, cur, 2'b00, ts, pol, n, lp, 1'b0};
  endfunction

  function automatic logic [21:0] mk_fb(input logic lp, input logic [5:0] a,
                                        input logic [10:0] b, input logic ps, input logic pd);
    return {1'b0, pd, ps, b, a, lp, 1'b1};
  endfunction

  // Outputs change 2.5 clocks after the strobe rises
  task automatic put(input logic [21:0] w);
    i_dps_host_model.send_word(w);
    repeat (4) @(negedge clk);
  endtask

  task automatic pd_case(input logic pri, input logic ts);
    int k;
    k = 0;
    put(mk_ref(pri, 14'h0005, 1'b0, ts, 1'b0));
    put(mk_fb(pri, 6'h01, 11'h002, 1'b0, 1'b1));
    chk(pri ? primary_cp_hiz : secondary_cp_hiz, 1'b1);
    chk(pri ? primary_powered_down : secondary_powered_down, ts);
    while ((pri ? primary_powered_down : secondary_powered_down) !== 1'b1 && k < 40) begin
      @(negedge clk);
      k++;
    end
    chk((k >= 3 && k <= `PD_SETTLE_CYC) || ts, 1'b1);
    chk(pri ? primary_powered_down : secondary_powered_down, 1'b1);
    if (k == 40) begin
      report_and_stop();
    end
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    chk(ref_osc_enable, 1'b1);
    chk(outputs_active, 1'b0);
    repeat (3) @(negedge clk);
    put(mk_ref(1'b0, 14'h2A5C, 1'b1, 1'b0, 1'b1));
    chk(secondary_ref_count, 14'h2A5C);
    chk(secondary_pfd_polarity, 1'b1);
    chk(secondary_cp_current, 1'b1);
    put(mk_fb(1'b0, 6'h2D, 11'h5B3, 1'b1, 1'b0));
    chk({secondary_main_count, secondary_swallow_count}, {11'h5B3, 6'h2D});
    chk(secondary_prescaler_select, 1'b1);
    put(mk_ref(1'b1, 14'h1234, 1'b1, 1'b0, 1'b1));
    chk(primary_ref_count, 14'h1234);
    chk(secondary_ref_count, 14'h2A5C);
    chk({primary_pfd_polarity, primary_cp_gain, multiplexed_output_pin}, 3'h7);
    chk(outputs_active, 1'b0);
    put(mk_fb(1'b1, 6'h15, 11'h3C7, 1'b1, 1'b0));
    chk({primary_main_count, primary_swallow_count}, {11'h3C7, 6'h15});
    chk(primary_prescaler_select, 1'b1);
    chk(outputs_active, 1'b1);
    put(mk_ref(1'b1, 14'h0001, 1'b0, 1'b1, 1'b0));
    chk({primary_pfd_polarity, primary_cp_gain, multiplexed_output_pin, primary_cp_hiz},
        4'h1);
    put(mk_ref(1'b0, 14'h0002, 1'b0, 1'b1, 1'b0));
    chk({secondary_pfd_polarity, secondary_cp_current, secondary_cp_hiz}, 3'h1);
    $display("Test latch steering done");
    pd_case(1'b0, 1'b0);
    chk(ref_osc_enable, 1'b1);
    pd_case(1'b1, 1'b1);
    chk(ref_osc_enable, 1'b0);
    put(mk_ref(1'b1, 14'h0ABC, 1'b0, 1'b1, 1'b0));
    chk(primary_ref_count, 14'h0ABC);
    put(mk_fb(1'b0, 6'h01, 11'h002, 1'b0, 1'b0));
    chk({secondary_powered_down, secondary_cp_hiz, ref_osc_enable}, 3'h1);
    put(mk_fb(1'b1, 6'h01, 11'h002, 1'b0, 1'b0));
    chk({primary_powered_down, primary_cp_hiz}, 2'h1);
    $display("Test power-down sequences done");
    pd_case(1'b0, 1'b1);
    pd_case(1'b1, 1'b0);
    $display("Test swapped power-down styles done");
    report_and_stop();
  end
endmodule
